// ==== rtl/fp_pkg.sv ====
// Purpose: Shared constants and carriers for the single-precision custom-instruction unit.
// Assumes: One processor clock; selector, operands and start come from the processor port.
// Notes:   Selector codes and cycle counts match the processor's custom-instruction table.
package fp_pkg;

   // -----------------------------------------------------------------
   // Operation selectors
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_DIV = 8'hff;
   localparam logic [7:0] OP_SUB = 8'hfe;
   localparam logic [7:0] OP_ADD = 8'hfd;
   localparam logic [7:0] OP_MUL = 8'hfc;
   localparam logic [7:0] OP_SQRT = 8'hfb;
   localparam logic [7:0] OP_I2F = 8'hfa;
   localparam logic [7:0] OP_F2I = 8'hf9;
   localparam logic [7:0] OP_RND = 8'hf8;
   localparam logic [7:0] OP_RSV_LO = 8'hea;
   localparam logic [7:0] OP_MIN = 8'he9;
   localparam logic [7:0] OP_MAX = 8'he8;
   localparam logic [7:0] OP_LT = 8'he7;
   localparam logic [7:0] OP_LE = 8'he6;
   localparam logic [7:0] OP_GT = 8'he5;
   localparam logic [7:0] OP_GE = 8'he4;
   localparam logic [7:0] OP_EQ = 8'he3;
   localparam logic [7:0] OP_NE = 8'he2;
   localparam logic [7:0] OP_NEG = 8'he1;
   localparam logic [7:0] OP_ABS = 8'he0;

   // -----------------------------------------------------------------
   // Cycle counts and format constants
   // -----------------------------------------------------------------
   localparam int CYC_DIV = 16;
   localparam int CYC_SQRT = 8;
   localparam int CYC_ADD = 5;
   localparam int CYC_MUL = 4;
   localparam int CYC_I2F = 4;
   localparam int CYC_F2I = 2;
   localparam int CYC_COMB = 1;
   localparam int EXP_BIAS = 127;
   localparam int EXP_MAX = 255;
   localparam logic [31:0] QNAN = 32'h7fc00000;
   localparam logic [31:0] INT_POS_SAT = 32'h7fffffff;
   localparam logic [31:0] INT_NEG_SAT = 32'h80000000;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_BUSY = 2'b10
   } phase_e;

   typedef struct packed {
      logic [7:0] sel;
      logic [31:0] a;
      logic [31:0] b;
   } ci_req_s;

   typedef struct packed {
      phase_e phase;
      logic [3:0] left;
      logic [7:0] sel;
      logic [31:0] res;
   } unit_state_s;

   localparam unit_state_s STATE_RESET = '{phase: PH_IDLE, left: 4'h0, sel: 8'h00, res: 32'h0};

endpackage : fp_pkg

// ==== rtl/fp_single_custom_insn_unit.sv ====
// Purpose: Single-precision floating-point datapath behind a custom-instruction port.
// Assumes: The processor holds start, selector and operands until done for multi-cycle ops.
// Notes:   One register stage is counted per cycle beyond the processor's own two.
//
// Notes on behaviour
// - Operation chosen by 8-bit code; 248-255 arithmetic, 224-233 compare; 234-247 undefined.
// - Divide 16, sqrt 8, add/sub 5, mul and int-to-float 4, float-to-int 2 cycles.
// - Min, max, compares, negate and absolute finish combinationally in one cycle.
// - An N-cycle operation holds N minus 2 internal register stages.
// - Divide and round use ties-away nearest; float-to-int truncates; rest faithful.
// - Faithful results stay within one unit in the last place.
// - Add, sub, mul, div, sqrt, float-to-int flush subnormal inputs to signed zero.
// - Compare, min, max, negate, absolute treat subnormal inputs exactly.
// - Only min, max, negate and absolute can yield a subnormal result, by passing an input through.
// - Signaling and quiet NaN inputs are alike; any NaN may be produced.
// - Invalid gives NaN, divide-by-zero and overflow infinity, underflow signed zero.
// - No traps and no sticky status flags.
// - Only single precision is handled in hardware.
// - Compares return 1 or 0; min picks a when a<b, max the other.
// - Legacy variant gives add, sub, mul, and divide only when built in.
// - Legacy variant flushes subnormal inputs and never outputs subnormals.
`timescale 1ns/1ns
module fp_single_custom_insn_unit #(
   parameter bit LEGACY_MODE = 1'b0,
   parameter bit DIV_PRESENT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire fp_pkg::ci_req_s req,
   output logic done,
   output logic [31:0] result
);
   import fp_pkg::*;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic int op_cycles(input logic [7:0] sel);
      unique case (sel)
         OP_DIV: op_cycles = CYC_DIV;
         OP_SQRT: op_cycles = CYC_SQRT;
         OP_ADD, OP_SUB: op_cycles = CYC_ADD;
         OP_MUL, OP_I2F: op_cycles = CYC_MUL;
         OP_F2I, OP_RND: op_cycles = CYC_F2I;
         default: op_cycles = CYC_COMB;
      endcase
   endfunction : op_cycles

   function automatic logic is_nan(input logic [31:0] x);
      is_nan = (x[30:23] == 8'hff) && (x[22:0] != 23'h0);
   endfunction : is_nan

   function automatic logic is_inf(input logic [31:0] x);
      is_inf = (x[30:23] == 8'hff) && (x[22:0] == 23'h0);
   endfunction : is_inf

   // Zero after flushing; subnormals count as zero here.
   function automatic logic is_fz(input logic [31:0] x);
      is_fz = (x[30:23] == 8'h00);
   endfunction : is_fz

   function automatic logic [23:0] mant(input logic [31:0] x);
      mant = is_fz(x) ? 24'h0 : {1'b1, x[22:0]};
   endfunction : mant

   // m[24] is the hidden bit, m[0] the guard bit below the last place.
   function automatic logic [31:0] packf(input logic s, input int e, input logic [24:0] m,
                                         input logic near);
      logic [24:0] r;
      int ex;
      r = {1'b0, m[24:1]} + {24'h0, near & m[0]};
      ex = e;
      if (r[24]) begin
         r = r >> 1;
         ex = ex + 1;
      end
      if (!m[24]) packf = {s, 31'h0};
      else if (ex >= EXP_MAX) packf = {s, 8'hff, 23'h0};
      else if (ex <= 0) packf = {s, 31'h0};
      else packf = {s, ex[7:0], r[22:0]};
   endfunction : packf

   // -----------------------------------------------------------------
   // Arithmetic
   // -----------------------------------------------------------------
   // Shifted-out bits are dropped; truncation keeps the error under one ulp.
   function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [26:0] ml;
      logic [26:0] ms;
      logic [27:0] sum;
      logic [27:0] norm;
      int d;
      int pos;
      if ({is_fz(a) ? 8'h0 : a[30:23], a[22:0]} >= {is_fz(b) ? 8'h0 : b[30:23], b[22:0]}) begin
         x = a;
         y = b;
      end else begin
         x = b;
         y = a;
      end
      d = int'(x[30:23]) - int'(y[30:23]);
      if (d > 27) d = 27;
      ml = {mant(x), 3'b000};
      ms = {mant(y), 3'b000} >> d;
      sum = (x[31] == y[31]) ? {1'b0, ml} + {1'b0, ms} : {1'b0, ml} - {1'b0, ms};
      pos = 0;
      for (int i = 0; i < 28; i++) begin
         if (sum[i]) pos = i;
      end
      norm = sum << (27 - pos);
      if (is_nan(a) || is_nan(b) || (is_inf(a) && is_inf(b) && a[31] != b[31])) begin
         fadd = QNAN;
      end else if (is_inf(x)) begin
         fadd = x;
      end else if (sum == 28'h0) begin
         fadd = {x[31] & y[31], 31'h0};
      end else begin
         fadd = packf(x[31], int'(x[30:23]) + pos - 26, norm[27:3], 1'b0);
      end
   endfunction : fadd

   function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
      logic [47:0] p;
      logic s;
      int e;
      s = a[31] ^ b[31];
      p = mant(a) * mant(b);
      e = int'(a[30:23]) + int'(b[30:23]) - EXP_BIAS;
      if (is_nan(a) || is_nan(b) || (is_inf(a) && is_fz(b)) || (is_fz(a) && is_inf(b)))
         fmul = QNAN;
      else if (is_inf(a) || is_inf(b)) fmul = {s, 8'hff, 23'h0};
      else if (is_fz(a) || is_fz(b)) fmul = {s, 31'h0};
      else if (p[47]) fmul = packf(s, e + 1, p[47:23], 1'b0);
      else fmul = packf(s, e, p[46:22], 1'b0);
   endfunction : fmul

   // Guard bit alone decides ties-away rounding, so no sticky bit is kept.
   function automatic logic [31:0] fdiv(input logic [31:0] a, input logic [31:0] b);
      logic [49:0] q;
      logic s;
      int e;
      s = a[31] ^ b[31];
      q = is_fz(b) ? 50'h0 : {mant(a), 26'h0} / 50'(mant(b));
      e = int'(a[30:23]) - int'(b[30:23]) + EXP_BIAS;
      if (is_nan(a) || is_nan(b) || (is_fz(a) && is_fz(b)) || (is_inf(a) && is_inf(b)))
         fdiv = QNAN;
      else if (is_inf(a) || is_fz(b)) fdiv = {s, 8'hff, 23'h0};
      else if (is_fz(a) || is_inf(b)) fdiv = {s, 31'h0};
      else if (q[26]) fdiv = packf(s, e, q[26:2], 1'b1);
      else fdiv = packf(s, e - 1, q[25:1], 1'b1);
   endfunction : fdiv

   function automatic logic [31:0] fsqrt(input logic [31:0] a);
      logic [47:0] rad;
      logic [23:0] root;
      logic [23:0] t;
      logic [8:0] esum;
      rad = a[23] ? {1'b0, mant(a), 23'h0} : {mant(a), 24'h0};
      root = 24'h0;
      for (int i = 23; i >= 0; i--) begin
         t = root | (24'h1 << i);
         if (48'(t * t) <= rad) root = t;
      end
      esum = {1'b0, a[30:23]} + 9'd126 + {8'h0, a[23]};
      if (is_nan(a) || (a[31] && !is_fz(a))) fsqrt = QNAN;
      else if (is_fz(a)) fsqrt = {a[31], 31'h0};
      else if (is_inf(a)) fsqrt = a;
      else fsqrt = {1'b0, esum[8:1], root[22:0]};
   endfunction : fsqrt

   // -----------------------------------------------------------------
   // Conversions
   // -----------------------------------------------------------------
   function automatic logic [31:0] fi2f(input logic [31:0] a);
      logic [31:0] mag;
      logic [31:0] n;
      int pos;
      mag = a[31] ? 32'(-a) : a;
      pos = 0;
      for (int i = 0; i < 32; i++) begin
         if (mag[i]) pos = i;
      end
      n = mag << (31 - pos);
      fi2f = (mag == 32'h0) ? 32'h0 : packf(a[31], EXP_BIAS + pos, n[31:7], 1'b0);
   endfunction : fi2f

   // Out-of-range and NaN inputs saturate; nothing flags them.
   function automatic logic [31:0] ff2i(input logic [31:0] a, input logic near);
      logic [63:0] full;
      logic [31:0] mag;
      int e;
      e = int'(a[30:23]) - EXP_BIAS;
      full = (e < -1) ? 64'h0 : {mant(a), 40'h0} >> (31 - e);
      mag = full[63:32] + {31'h0, near & full[31]};
      if (is_nan(a)) ff2i = INT_NEG_SAT;
      else if (e >= 31) ff2i = a[31] ? INT_NEG_SAT : INT_POS_SAT;
      else if (is_fz(a)) ff2i = 32'h0;
      else ff2i = a[31] ? 32'(-mag) : mag;
   endfunction : ff2i

   // -----------------------------------------------------------------
   // Exact compares
   // -----------------------------------------------------------------
   function automatic logic [31:0] okey(input logic [31:0] x);
      okey = x[31] ? ~x : (x | 32'h80000000);
   endfunction : okey

   logic anyNan;
   logic bothZero;
   logic aLtB;
   logic bLtA;
   logic aEqB;

   always_comb begin
      anyNan = is_nan(req.a) || is_nan(req.b);
      bothZero = (req.a[30:0] == 31'h0) && (req.b[30:0] == 31'h0);
      aLtB = !anyNan && !bothZero && (okey(req.a) < okey(req.b));
      bLtA = !anyNan && !bothZero && (okey(req.b) < okey(req.a));
      aEqB = !anyNan && ((req.a == req.b) || bothZero);
   end

   // -----------------------------------------------------------------
   // Operation select
   // -----------------------------------------------------------------
   logic [31:0] opResult;
   logic opLegal;

   always_comb begin
      opLegal = 1'b1;
      unique case (req.sel)
         OP_DIV: opResult = fdiv(req.a, req.b);
         OP_SUB: opResult = fadd(req.a, {~req.b[31], req.b[30:0]});
         OP_ADD: opResult = fadd(req.a, req.b);
         OP_MUL: opResult = fmul(req.a, req.b);
         OP_SQRT: opResult = fsqrt(req.a);
         OP_I2F: opResult = fi2f(req.a);
         OP_F2I: opResult = ff2i(req.a, 1'b0);
         OP_RND: opResult = ff2i(req.a, 1'b1);
         OP_MIN: opResult = aLtB ? req.a : req.b;
         OP_MAX: opResult = aLtB ? req.b : req.a;
         OP_LT: opResult = {31'h0, aLtB};
         OP_LE: opResult = {31'h0, aLtB | aEqB};
         OP_GT: opResult = {31'h0, bLtA};
         OP_GE: opResult = {31'h0, bLtA | aEqB};
         OP_EQ: opResult = {31'h0, aEqB};
         OP_NE: opResult = {31'h0, ~aEqB};
         OP_NEG: opResult = {~req.a[31], req.a[30:0]};
         OP_ABS: opResult = {1'b0, req.a[30:0]};
         default: opResult = 32'h0;
      endcase
      // Trimmed build keeps only the original arithmetic; the rest reads as zero.
      if (LEGACY_MODE) begin
         opLegal = (req.sel == OP_ADD) || (req.sel == OP_SUB) || (req.sel == OP_MUL)
                   || ((req.sel == OP_DIV) && DIV_PRESENT);
      end
      if (!opLegal) opResult = 32'h0;
   end

   // -----------------------------------------------------------------
   // Latency control
   // -----------------------------------------------------------------
   unit_state_s st;
   unit_state_s next_st;
   logic idle;
   logic takeMulti;
   logic takeShort;
   int stages;

   always_comb begin
      idle = (st.phase == PH_IDLE);
      stages = op_cycles(req.sel) - 2;
      takeMulti = idle && start && (stages > 0);
      takeShort = idle && start && (stages <= 0);
   end

   always_comb begin
      next_st = st;
      unique case (st.phase)
         PH_IDLE: begin
            if (takeMulti) begin
               next_st.phase = PH_BUSY;
               next_st.left = 4'(stages - 1);
               next_st.sel = req.sel;
               next_st.res = opResult;
            end
         end
         PH_BUSY: begin
            if (st.left == 4'h0) next_st.phase = PH_IDLE;
            else next_st.left = st.left - 4'h1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Exceptions show only in the result value; there is no flag or trap output.
   assign done = takeShort || ((st.phase == PH_BUSY) && (st.left == 4'h0));
   assign result = (st.phase == PH_BUSY) ? st.res : opResult;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic [7:0] outSel;
   logic outIsFloat;
   assign outSel = (st.phase == PH_BUSY) ? st.sel : req.sel;
   assign outIsFloat = (outSel == OP_DIV) || (outSel == OP_SUB) || (outSel == OP_ADD)
                       || (outSel == OP_MUL) || (outSel == OP_SQRT) || (outSel == OP_I2F);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_div_latency: assert property (idle && start && req.sel == OP_DIV
      |-> !done ##14 done) else $error("divide result not at cycle 16");
   a_sqrt_latency: assert property (idle && start && req.sel == OP_SQRT
      |-> ##6 done) else $error("square root result not at cycle 8");
   a_add_latency: assert property (idle && start && req.sel == OP_ADD
      |-> (!done)[*3] ##1 done) else $error("add done not at cycle 5");
   // A short op issued right after the pulse may raise done again, so the check ends on idle.
   a_mul_done: assert property (idle && start && req.sel == OP_MUL
      |-> !done ##1 !done ##1 done ##1 idle) else $error("multiply done not a single pulse at cycle 4");
   a_short_ops: assert property (idle && start && stages <= 0
      |-> done) else $error("single-cycle operation did not finish at once");
   a_cmp_bool: assert property (done && outSel inside {[OP_NE:OP_LT]}
      |-> result[31:1] == 31'h0) else $error("comparison returned non-boolean");
   a_no_subnormal: assert property (done && outIsFloat
      |-> !(result[30:23] == 8'h00 && result[22:0] != 23'h0)) else $error("subnormal result");
   a_add_nan: assert property (idle && start && req.sel == OP_ADD && is_nan(req.a)
      |-> ##3 is_nan(result)) else $error("add of NaN gave non-NaN");
   a_neg_exact: assert property (done && idle && req.sel == OP_NEG
      |-> result == {~req.a[31], req.a[30:0]}) else $error("negate altered magnitude");
   a_held_result: assert property (st.phase == PH_BUSY && !done
      |=> $stable(result)) else $error("result moved before done");

   c_divide: cover property (idle && start && req.sel == OP_DIV ##14 done);
   c_compare: cover property (done && idle && req.sel == OP_LT && result[0]);
   c_back_to_back: cover property (done && st.phase == PH_BUSY ##1 idle && start);

endmodule : fp_single_custom_insn_unit

// ==== bench/ci_port_model.sv ====
// Purpose: Processor-side model of the custom-instruction port that feeds the unit.
// Assumes: Requests change at falling edges; done and result settle within 2 ns.
// Notes:   Released operand lines show the inverse of their last value, never a stale copy.
`timescale 1ns/1ns
module ci_port_model (
   input wire logic clk,
   input wire logic done,
   input wire logic [31:0] result,
   output logic start,
   output fp_pkg::ci_req_s req
);
   import fp_pkg::*;

   initial begin
      start = 1'b0;
      req = '0;
   end

   // -----------------------------------------------------------------
   // Request issue
   // -----------------------------------------------------------------
   // Called at a falling edge; returns at a falling edge with the request still held,
   // so the caller either issues the next one at once or releases the port.
   task automatic run(input logic [7:0] s, input logic [31:0] a, input logic [31:0] b,
         input int stall, output logic [31:0] res, output int lat);
      int k;
      if (stall > 0) begin
         // A consumer of a late result waits stall idle cycles before issuing.
         start <= 1'b0;
         req <= ~req;
         repeat (stall) @(negedge clk);
      end
      start <= 1'b1;
      req <= '{sel: s, a: a, b: b};
      lat = -1;
      res = 32'h0;
      for (k = 0; k < 40 && lat < 0; k++) begin
         #2;
         if (done === 1'b1) begin
            lat = k;
            res = result;
         end
         @(negedge clk);
      end
   endtask : run

   task automatic rest();
      start <= 1'b0;
      req <= ~req;
      @(negedge clk);
   endtask : rest

endmodule : ci_port_model

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the single-precision custom-instruction unit.
// Assumes: Expected values are worked out by hand from single-precision encodings.
// Notes:   A second unit built as the reduced variant without divide runs at the end.
`timescale 1ns/1ns
`define CHECK(got, exp) begin nChecks++; if ((got) !== (exp)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
   import fp_pkg::*;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start, startLeg, done, doneLeg;
   logic [31:0] result, resultLeg, lastRes;
   ci_req_s req, reqLeg;
   bit leg = 1'b0;
   bit tol = 1'b0;
   int gap = 0;
   int errors = 0;
   int nChecks = 0;

   always #4 clk = ~clk;

   fp_single_custom_insn_unit fp_single_custom_insn_unit_inst (.clk(clk), .rst_b(rst_b),
      .start(start), .req(req), .done(done), .result(result));
   fp_single_custom_insn_unit #(.LEGACY_MODE(1'b1), .DIV_PRESENT(1'b0))
      fp_single_custom_insn_unit_inst_legacy (.clk(clk), .rst_b(rst_b), .start(startLeg),
      .req(reqLeg), .done(doneLeg), .result(resultLeg));
   ci_port_model ci_port_model_inst (.clk(clk), .done(done), .result(result), .start(start),
      .req(req));
   ci_port_model ci_port_model_inst_legacy (.clk(clk), .done(doneLeg), .result(resultLeg),
      .start(startLeg), .req(reqLeg));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // A negative expected latency skips the timing compare.
   task automatic op(input logic [7:0] s, input logic [31:0] a, input logic [31:0] b,
         input logic [31:0] exp, input int expLat);
      int lat;
      logic [31:0] got;
      if (leg) begin
         ci_port_model_inst_legacy.run(s, a, b, gap, lastRes, lat);
      end else begin
         ci_port_model_inst.run(s, a, b, gap, lastRes, lat);
      end
      gap = 0;
      if (lat < 0) begin
         errors++;
         $display("Error at %0t: no completion for code %h", $time, s);
         print_verdict();
      end else begin
         // Faithful results may land on the value one step above the lower neighbour.
         got = (tol && lastRes === exp + 32'h1) ? exp : lastRes;
         `CHECK(got, exp)
         if (expLat >= 0) begin
            `CHECK(lat, expLat)
         end
      end
   endtask : op

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic test_arith();
      op(OP_DIV, 32'h40c00000, 32'h40000000, 32'h40400000, 14);
      op(OP_SUB, 32'h40400000, 32'h3f800000, 32'h40000000, 3);
      op(OP_ADD, 32'h3f800000, 32'h40000000, 32'h40400000, 3);
      op(OP_MUL, 32'h40000000, 32'h40400000, 32'h40c00000, 2);
      gap = 2;
      op(OP_SQRT, 32'h40800000, 32'h0, 32'h40000000, 6);
      op(OP_I2F, 32'h00000007, 32'h0, 32'h40e00000, 2);
      op(OP_I2F, 32'hffffffff, 32'h0, 32'hbf800000, 2);
      op(OP_F2I, 32'hc0300000, 32'h0, 32'hfffffffe, 0);
      op(OP_RND, 32'h40200000, 32'h0, 32'h00000003, 0);
      op(OP_RND, 32'hc0200000, 32'h0, 32'hfffffffd, 0);
      op(OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaab, 14);
      tol = 1'b1;
      op(OP_ADD, 32'h3f800000, 32'h33800000, 32'h3f800000, 3);
      op(OP_MUL, 32'h3f800001, 32'h3f800001, 32'h3f800002, 2);
      tol = 1'b0;
      $display("test_arith finished");
   endtask : test_arith

   task automatic test_special();
      op(OP_DIV, 32'hbf800000, 32'h0, 32'hff800000, 14);
      op(OP_DIV, 32'h3f800000, 32'h00000001, 32'h7f800000, 14);
      op(OP_MUL, 32'h7f000000, 32'h40000000, 32'h7f800000, 2);
      op(OP_MUL, 32'h80800000, 32'h00800000, 32'h80000000, 2);
      op(OP_SQRT, 32'hc0800000, 32'h0, QNAN, 6);
      op(OP_ADD, 32'h7f800001, 32'h3f800000, QNAN, 3);
      op(OP_ADD, 32'h7fc00000, 32'h3f800000, QNAN, 3);
      op(OP_MUL, 32'h00400000, 32'h7f000000, 32'h00000000, 2);
      op(OP_MUL, 32'h80000001, 32'h3f800000, 32'h80000000, 2);
      op(OP_F2I, 32'h00000001, 32'h0, 32'h00000000, 0);
      op(OP_LT, 32'h7f800001, 32'h3f800000, 32'h00000000, 0);
      $display("test_special finished");
   endtask : test_special

   task automatic test_compare();
      op(OP_MIN, 32'h3f800000, 32'h40000000, 32'h3f800000, 0);
      op(OP_MAX, 32'h3f800000, 32'h40000000, 32'h40000000, 0);
      op(OP_MIN, 32'h00000002, 32'h00000001, 32'h00000001, 0);
      op(OP_MAX, 32'hbf800000, 32'hc0000000, 32'hbf800000, 0);
      op(OP_LT, 32'h00000001, 32'h00000002, 32'h00000001, 0);
      op(OP_LT, 32'h40000000, 32'h3f800000, 32'h00000000, 0);
      op(OP_LE, 32'h40000000, 32'h40000000, 32'h00000001, 0);
      op(OP_GT, 32'h40000000, 32'h3f800000, 32'h00000001, 0);
      op(OP_GT, 32'h3f800000, 32'h40000000, 32'h00000000, 0);
      op(OP_GE, 32'h3f800000, 32'h40000000, 32'h00000000, 0);
      op(OP_GE, 32'h00000002, 32'h00000001, 32'h00000001, 0);
      op(OP_EQ, 32'h00000001, 32'h00000002, 32'h00000000, 0);
      op(OP_EQ, 32'h80000000, 32'h00000000, 32'h00000001, 0);
      op(OP_NE, 32'h00000001, 32'h00000002, 32'h00000001, 0);
      op(OP_NEG, 32'h00000001, 32'h0, 32'h80000001, 0);
      op(OP_ABS, 32'h80000003, 32'h0, 32'h00000003, 0);
      $display("test_compare finished");
   endtask : test_compare

   task automatic test_reserved();
      for (int c = int'(OP_RSV_LO); c < int'(OP_RND); c++) begin
         op(c[7:0], 32'h3f800000, 32'h40000000, 32'h00000000, 0);
      end
      $display("test_reserved finished");
   endtask : test_reserved

   task automatic test_legacy();
      op(OP_ADD, 32'h3f800000, 32'h40000000, 32'h40400000, 3);
      op(OP_MUL, 32'h40000000, 32'h40400000, 32'h40c00000, 2);
      op(OP_MUL, 32'h00400000, 32'h7f000000, 32'h00000000, 2);
      op(OP_MUL, 32'h00800000, 32'h00800000, 32'h00000000, 2);
      op(OP_DIV, 32'h40c00000, 32'h40000000, 32'h00000000, -1);
      op(OP_SQRT, 32'h40800000, 32'h0, 32'h00000000, -1);
      ci_port_model_inst_legacy.rest();
      $display("test_legacy finished");
   endtask : test_legacy

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      test_arith();
      test_special();
      test_compare();
      test_reserved();
      ci_port_model_inst.rest();
      leg = 1'b1;
      test_legacy();
      print_verdict();
   end

endmodule : testbench
